// ==== gr_defines.svh ====
`ifndef GR_DEFINES_SVH
`define GR_DEFINES_SVH

`define GR_OFS_RANGE_SEL  16'h0001
`define GR_OFS_TEST_DATA  16'h0002
`define GR_OFS_TEST_STB   16'h0003
`define GR_OFS_SYNC_STB   16'h0004
`define GR_OFS_SYNC_FB    16'h0005
`define GR_OFS_HARD_RST   16'h0006

`define GR_RANGE_RESET    32'h00000000
`define GR_TEST_RESET     32'h00000000
`define GR_RANGE_WMASK    32'h0000ffff
`define GR_TEST_WMASK     32'h02f7ffff
`define GR_READ_ZERO      32'h00000000

`define GR_TD_DATA        15:0
`define GR_TD_SIGN        15
`define GR_RANGE_FIELD    15:0
`define GR_TD_EXP         18:16
`define GR_TD_DBG_EN      23:20
`define GR_EXT_SIGN       7

`define GR_TEN_OFF        3'h0
`define GR_TEN_ON         3'h1
`define GR_TEN_STROBE     3'h2

`define GR_DBG_RC         15:10
`define GR_DBG_RSMP       9:8
`define GR_DBG_AGC        7:4
`define GR_DBG_NCO        3
`define GR_DBG_FIFO       2:0
`define GR_FIFO_ZERO      3'h0
`endif

// ==== gr_pkg.sv ====
package gr_pkg;
	typedef logic [31:0] word_t;
	typedef logic [15:0] word_addr_t;
	typedef logic [15:0] range_sel_t;
	typedef logic [22:0] scaled_t;
	typedef enum {
		CMD_NONE,
		CMD_TEST,
		CMD_SYNC,
		CMD_SYNC_FB,
		CMD_HARD_RST
	} strobe_cmd_t;
endpackage : gr_pkg

// ==== strobe_pulse_gen.sv ====
`timescale 1ns/100ps
`include "gr_defines.svh"
module strobe_pulse_gen (
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  gr_pkg::strobe_cmd_t cmd,
	output logic              test_en_pulse_q,
	output logic              sync_pulse_q,
	output logic              sync_fb_q,
	output logic              hard_rst_q
);
	import gr_pkg::*;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			test_en_pulse_q <= 1'b0;
		end else begin
			test_en_pulse_q <= (cmd == CMD_TEST);
		end
	end

	// Both sync strobes pulse the pin
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sync_pulse_q <= 1'b0;
			sync_fb_q    <= 1'b0;
		end else begin
			sync_pulse_q <= (cmd == CMD_SYNC) || (cmd == CMD_SYNC_FB);
			sync_fb_q    <= (cmd == CMD_SYNC_FB);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hard_rst_q <= 1'b0;
		end else begin
			hard_rst_q <= (cmd == CMD_HARD_RST);
		end
	end
endmodule : strobe_pulse_gen

// ==== debug_bus_mux.sv ====
`timescale 1ns/100ps
`include "gr_defines.svh"
module debug_bus_mux #(
	parameter int NUM_CH = 4,
	parameter int DATA_W = 16
) (
	input  wire logic                  ref_clk,
	input  wire logic                  reset_n,
	input  wire logic [NUM_CH-1:0]     dbg_en,
	input  wire logic [NUM_CH*DATA_W-1:0] norm_out_bus,
	input  wire logic [NUM_CH*6-1:0]   rc_obs,
	input  wire logic [NUM_CH*2-1:0]   rsmp_carry,
	input  wire logic [NUM_CH*4-1:0]   agc_obs,
	input  wire logic [NUM_CH-1:0]     nco_msb,
	input  wire logic [NUM_CH*3-1:0]   fifo_rd_addr,
	input  wire logic [NUM_CH-1:0]     fifo_empty,
	output logic [NUM_CH*DATA_W-1:0]   channel_output_bus,
	output logic [NUM_CH*DATA_W-1:0]   debug_observe_bus
);
	import gr_pkg::*;

	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		logic [DATA_W-1:0] dbg;
		always_comb begin
			dbg = '0;
			dbg[`GR_DBG_RC]   = rc_obs[i*6 +: 6];
			dbg[`GR_DBG_RSMP] = rsmp_carry[i*2 +: 2];
			dbg[`GR_DBG_AGC]  = agc_obs[i*4 +: 4];
			dbg[`GR_DBG_NCO]  = nco_msb[i];
			dbg[`GR_DBG_FIFO] = fifo_empty[i] ? `GR_FIFO_ZERO
			                                  : fifo_rd_addr[i*3 +: 3];
		end

		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				debug_observe_bus[i*DATA_W +: DATA_W] <= '0;
			end else begin
				debug_observe_bus[i*DATA_W +: DATA_W] <= dbg;
			end
		end

		// OR debug word onto the output bus
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				channel_output_bus[i*DATA_W +: DATA_W] <= '0;
			end else begin
				channel_output_bus[i*DATA_W +: DATA_W] <=
				    norm_out_bus[i*DATA_W +: DATA_W] |
				    (dbg_en[i] ? dbg : '0);
			end
		end

		a_debug_or_out: assert property (@(posedge ref_clk)
		    disable iff (!reset_n)
		    dbg_en[i] |=> ((channel_output_bus[i*DATA_W +: DATA_W] &
		    debug_observe_bus[i*DATA_W +: DATA_W]) ==
		    debug_observe_bus[i*DATA_W +: DATA_W]))
		    else $error("debug bits missing from output bus");

		a_debug_off_pass: assert property (@(posedge ref_clk)
		    disable iff (!reset_n)
		    !dbg_en[i] |=> (channel_output_bus[i*DATA_W +: DATA_W] ==
		    $past(norm_out_bus[i*DATA_W +: DATA_W])))
		    else $error("output bus altered while debug disabled");
	end
endmodule : debug_bus_mux

// ==== global_test_sync_reset_regs.sv ====
`timescale 1ns/100ps
`include "gr_defines.svh"
module global_test_sync_reset_regs #(
	parameter int NUM_CH = 4,
	parameter int DATA_W = 16,
	parameter int EXP_W  = 3
) (
	input  wire logic                      ref_clk,
	input  wire logic                      reset_n,
	input  gr_pkg::word_addr_t             global_word_address,
	input  wire logic                      host_wr_en,
	input  wire logic                      host_rd_en,
	input  gr_pkg::word_t                  host_wdata,
	output gr_pkg::word_t                  host_rdata,
	input  wire logic [NUM_CH-1:0]         chan_test_select,
	input  wire logic [NUM_CH*3-1:0]       chan_test_en_mode,
	input  wire logic [NUM_CH*DATA_W-1:0]  norm_data,
	input  wire logic [NUM_CH*EXP_W-1:0]   norm_exp,
	input  wire logic [NUM_CH-1:0]         norm_en,
	output logic [NUM_CH*DATA_W-1:0]       chan_sample_data,
	output logic [NUM_CH*EXP_W-1:0]        chan_sample_exp,
	output logic [NUM_CH-1:0]              chan_sample_en,
	output gr_pkg::scaled_t                test_sample_scaled,
	input  wire logic                      sync_input_primary,
	input  wire logic                      sync_input_secondary,
	output logic                           sync_pulse_out,
	output logic                           sync_primary_evt,
	output logic                           sync_secondary_evt,
	input  wire logic [NUM_CH-1:0]         soft_chan_reset,
	output logic [NUM_CH-1:0]              chan_slave_clear,
	output logic                           hard_reset_out,
	output gr_pkg::range_sel_t             range_source_select,
	output logic [NUM_CH-1:0]              debug_enable,
	input  wire logic [NUM_CH*DATA_W-1:0]  norm_out_bus,
	input  wire logic [NUM_CH*6-1:0]       rc_obs,
	input  wire logic [NUM_CH*2-1:0]       rsmp_carry,
	input  wire logic [NUM_CH*4-1:0]       agc_obs,
	input  wire logic [NUM_CH-1:0]         nco_msb,
	input  wire logic [NUM_CH*3-1:0]       fifo_rd_addr,
	input  wire logic [NUM_CH-1:0]         fifo_empty,
	output logic [NUM_CH*DATA_W-1:0]       channel_output_bus,
	output logic [NUM_CH*DATA_W-1:0]       debug_observe_bus
);
	import gr_pkg::*;

	word_t       range_sel_q;
	word_t       test_data_q;
	word_t       rdata_q;
	strobe_cmd_t cmd;
	logic        test_en_pulse;
	logic        sync_fb;
	logic        hard_rst;
	logic        ctrl_rst;
	logic        sync_pri_q;
	logic        sync_sec_q;
	logic        hard_out_q;
	logic [NUM_CH-1:0] slave_clr_q;
	scaled_t     scaled_q;

	// Maps a write address onto a strobe command
	function automatic strobe_cmd_t decode_strobe(
		input logic wr,
		input word_addr_t adr
	);
		decode_strobe = CMD_NONE;
		if (wr) begin
			case (adr)
				`GR_OFS_TEST_STB: decode_strobe = CMD_TEST;
				`GR_OFS_SYNC_STB: decode_strobe = CMD_SYNC;
				`GR_OFS_SYNC_FB:  decode_strobe = CMD_SYNC_FB;
				`GR_OFS_HARD_RST: decode_strobe = CMD_HARD_RST;
				default:          decode_strobe = CMD_NONE;
			endcase
		end
	endfunction : decode_strobe

	// Sign-extends the test word and shifts it by 6 dB steps
	function automatic scaled_t scale_test(input word_t td);
		scaled_t ext;
		ext = {{`GR_EXT_SIGN{td[`GR_TD_SIGN]}}, td[`GR_TD_DATA]};
		scale_test = ext << td[`GR_TD_EXP];
	endfunction : scale_test

	// Strobes decode from the write event alone
	assign cmd = decode_strobe(host_wr_en, global_word_address);

	strobe_pulse_gen u_strobe (
		.ref_clk         (ref_clk),
		.reset_n         (reset_n),
		.cmd             (cmd),
		.test_en_pulse_q (test_en_pulse),
		.sync_pulse_q    (sync_pulse_out),
		.sync_fb_q       (sync_fb),
		.hard_rst_q      (hard_rst)
	);

	// Software reset acts like the pin on control state
	assign ctrl_rst = !reset_n || hard_rst;

	always_ff @(posedge ref_clk) begin
		if (ctrl_rst) begin
			range_sel_q <= `GR_RANGE_RESET;
		end else if (host_wr_en &&
		             global_word_address == `GR_OFS_RANGE_SEL) begin
			range_sel_q <= host_wdata & `GR_RANGE_WMASK;
		end
	end

	// Data, exponent and debug enables kept together
	always_ff @(posedge ref_clk) begin
		if (ctrl_rst) begin
			test_data_q <= `GR_TEST_RESET;
		end else if (host_wr_en &&
		             global_word_address == `GR_OFS_TEST_DATA) begin
			test_data_q <= host_wdata & `GR_TEST_WMASK;
		end
	end

	// Strobe locations read back zero
	always_ff @(posedge ref_clk) begin
		if (ctrl_rst) begin
			rdata_q <= `GR_READ_ZERO;
		end else if (host_rd_en) begin
			case (global_word_address)
				`GR_OFS_RANGE_SEL: rdata_q <= range_sel_q;
				`GR_OFS_TEST_DATA: rdata_q <= test_data_q;
				default:           rdata_q <= `GR_READ_ZERO;
			endcase
		end
	end

	assign host_rdata          = rdata_q;
	assign range_source_select = range_sel_q[`GR_RANGE_FIELD];

	// Exponent gain applied to the test sample
	always_ff @(posedge ref_clk) begin
		if (ctrl_rst) begin
			scaled_q <= '0;
		end else begin
			scaled_q <= scale_test(test_data_q);
		end
	end

	assign test_sample_scaled = scaled_q;

	for (genvar i = 0; i < NUM_CH; i++) begin : g_src
		logic [2:0] mode;
		logic       ten;
		assign mode = chan_test_en_mode[i*3 +: 3];

		// Mode comes from the channel's own field
		always_comb begin
			case (mode)
				`GR_TEN_ON:     ten = 1'b1;
				`GR_TEN_STROBE: ten = test_en_pulse;
				default:        ten = 1'b0;
			endcase
		end

		// Each channel may take the test word
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				chan_sample_data[i*DATA_W +: DATA_W] <= '0;
				chan_sample_exp[i*EXP_W +: EXP_W]    <= '0;
				chan_sample_en[i]                    <= 1'b0;
			end else if (chan_test_select[i]) begin
				chan_sample_data[i*DATA_W +: DATA_W] <=
				    test_data_q[`GR_TD_DATA];
				chan_sample_exp[i*EXP_W +: EXP_W]    <=
				    test_data_q[`GR_TD_EXP];
				chan_sample_en[i]                    <= ten;
			end else begin
				chan_sample_data[i*DATA_W +: DATA_W] <=
				    norm_data[i*DATA_W +: DATA_W];
				chan_sample_exp[i*EXP_W +: EXP_W]    <=
				    norm_exp[i*EXP_W +: EXP_W];
				chan_sample_en[i]                    <= norm_en[i];
			end
		end

		a_strobe_enable: assert property (@(posedge ref_clk)
		    disable iff (!reset_n)
		    (chan_test_select[i] && mode == `GR_TEN_STROBE)
		    |=> (chan_sample_en[i] == $past(test_en_pulse)))
		    else $error("strobe mode enable mismatch");

		a_test_source_sel: assert property (@(posedge ref_clk)
		    disable iff (!reset_n)
		    chan_test_select[i] |=>
		    (chan_sample_data[i*DATA_W +: DATA_W] ==
		    $past(test_data_q[`GR_TD_DATA])))
		    else $error("test word not routed to channel");
	end

	// Feedback enters at the pin's input register
	// External sync is taken as synchronous
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sync_pri_q <= 1'b0;
		end else begin
			sync_pri_q <= sync_input_primary || sync_fb;
		end
	end

	// Secondary sync kept apart from the primary
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sync_sec_q <= 1'b0;
		end else begin
			sync_sec_q <= sync_input_secondary;
		end
	end

	assign sync_primary_evt   = sync_pri_q;
	assign sync_secondary_evt = sync_sec_q;

	// Channel soft reset touches slave copies only
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			slave_clr_q <= '0;
		end else begin
			slave_clr_q <= soft_chan_reset;
		end
	end

	assign chan_slave_clear = slave_clr_q;

	// Reset broadcast to the rest of the chip
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hard_out_q <= 1'b1;
		end else begin
			hard_out_q <= hard_rst;
		end
	end

	assign hard_reset_out = hard_out_q;

	// Debug routing enables for buses A to D
	assign debug_enable = test_data_q[`GR_TD_DBG_EN];

	debug_bus_mux #(
		.NUM_CH (NUM_CH),
		.DATA_W (DATA_W)
	) u_dbg (
		.ref_clk            (ref_clk),
		.reset_n            (reset_n),
		.dbg_en             (test_data_q[`GR_TD_DBG_EN]),
		.norm_out_bus       (norm_out_bus),
		.rc_obs             (rc_obs),
		.rsmp_carry         (rsmp_carry),
		.agc_obs            (agc_obs),
		.nco_msb            (nco_msb),
		.fifo_rd_addr       (fifo_rd_addr),
		.fifo_empty         (fifo_empty),
		.channel_output_bus (channel_output_bus),
		.debug_observe_bus  (debug_observe_bus)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence s_fb_write;
		host_wr_en && global_word_address == `GR_OFS_SYNC_FB;
	endsequence

	sequence s_sync_write;
		host_wr_en && global_word_address == `GR_OFS_SYNC_STB;
	endsequence

	sequence s_fb_seen;
		sync_pulse_out ##1 sync_primary_evt;
	endsequence

	a_test_strobe_width: assert property (
	    (cmd == CMD_TEST) ##1 (cmd != CMD_TEST)
	    |-> test_en_pulse ##1 !test_en_pulse)
	    else $error("test enable not one clock wide");

	a_sync_out_pulse: assert property (
	    s_sync_write ##1 !(cmd == CMD_SYNC || cmd == CMD_SYNC_FB)
	    |-> sync_pulse_out ##1 !sync_pulse_out)
	    else $error("sync output pulse width wrong");

	a_sync_out_cause: assert property (
	    sync_pulse_out |->
	    $past(cmd == CMD_SYNC || cmd == CMD_SYNC_FB))
	    else $error("sync output without a strobe write");

	a_feedback_loop: assert property (
	    s_fb_write |=> s_fb_seen)
	    else $error("feedback sync not seen on primary input");

	a_hard_reset_regs: assert property (
	    host_wr_en && global_word_address == `GR_OFS_HARD_RST
	    |-> ##2 (test_data_q == `GR_TEST_RESET &&
	    range_sel_q == `GR_RANGE_RESET && hard_reset_out))
	    else $error("software reset left control state");

	a_test_data_write: assert property (
	    host_wr_en && global_word_address == `GR_OFS_TEST_DATA &&
	    !hard_rst |=> test_data_q == $past(host_wdata & `GR_TEST_WMASK))
	    else $error("test register did not take the write");

	a_soft_reset_scope: assert property (
	    (soft_chan_reset != '0) && !host_wr_en && !hard_rst
	    |=> $stable(test_data_q) && $stable(range_sel_q) &&
	    chan_slave_clear == $past(soft_chan_reset))
	    else $error("channel reset disturbed control state");

	a_sync_secondary: assert property (
	    sync_input_secondary && !sync_input_primary && !sync_fb
	    |=> sync_secondary_evt && !sync_primary_evt)
	    else $error("secondary sync not independent");

	a_gain_scale: assert property (
	    $stable(test_data_q) && !hard_rst && test_data_q[`GR_TD_EXP] == 3'h7
	    |=> test_sample_scaled[6:0] == 7'h00)
	    else $error("top exponent code lacks 42 dB shift");
endmodule : global_test_sync_reset_regs

// ==== host_cpu_model.sv ====
`timescale 1ns/100ps
module host_cpu_model (
	input  wire logic    ref_clk,
	output gr_pkg::word_addr_t global_word_address,
	output logic          host_wr_en,
	output logic          host_rd_en,
	output gr_pkg::word_t host_wdata,
	input  gr_pkg::word_t host_rdata,
	output logic          sync_input_primary,
	output logic          sync_input_secondary
);
	import gr_pkg::*;
	initial begin
		global_word_address = 16'h0000;
		host_wr_en = 1'b0;
		host_rd_en = 1'b0;
		host_wdata = 32'h00000000;
		sync_input_primary = 1'b0;
		sync_input_secondary = 1'b0;
	end
	// Idle bus shows the inverse of the last value, never a stale copy
	task automatic release_bus;
		global_word_address = ~global_word_address;
		host_wdata = ~host_wdata;
	endtask : release_bus
	task automatic write_reg(input word_addr_t adr, input word_t data);
		@(posedge ref_clk);
		#1;
		global_word_address = adr;
		host_wdata = data;
		host_wr_en = 1'b1;
		@(posedge ref_clk);
		#1;
		host_wr_en = 1'b0;
		release_bus();
	endtask : write_reg
	task automatic read_reg(input word_addr_t adr, output word_t data);
		@(posedge ref_clk);
		#1;
		global_word_address = adr;
		host_rd_en = 1'b1;
		@(posedge ref_clk);
		#1;
		host_rd_en = 1'b0;
		data = host_rdata;
		release_bus();
	endtask : read_reg
	task automatic sync_pulse(input bit second);
		@(posedge ref_clk);
		#1;
		if (second) sync_input_secondary = 1'b1;
		else sync_input_primary = 1'b1;
		@(posedge ref_clk);
		#1;
		sync_input_primary = 1'b0;
		sync_input_secondary = 1'b0;
	endtask : sync_pulse
endmodule : host_cpu_model

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
	import gr_pkg::*;
	logic        ref_clk;
	logic        reset_n;
	word_addr_t  global_word_address;
	logic        host_wr_en;
	logic        host_rd_en;
	word_t       host_wdata;
	word_t       host_rdata;
	logic [3:0]  chan_test_select;
	logic [11:0] chan_test_en_mode;
	logic [63:0] norm_data;
	logic [11:0] norm_exp;
	logic [3:0]  norm_en;
	logic [63:0] chan_sample_data;
	logic [11:0] chan_sample_exp;
	logic [3:0]  chan_sample_en;
	scaled_t     test_sample_scaled;
	logic        sync_input_primary;
	logic        sync_input_secondary;
	logic        sync_pulse_out;
	logic        sync_primary_evt;
	logic        sync_secondary_evt;
	logic [3:0]  soft_chan_reset;
	logic [3:0]  chan_slave_clear;
	logic        hard_reset_out;
	range_sel_t  range_source_select;
	logic [3:0]  debug_enable;
	logic [63:0] norm_out_bus;
	logic [23:0] rc_obs;
	logic [7:0]  rsmp_carry;
	logic [15:0] agc_obs;
	logic [3:0]  nco_msb;
	logic [11:0] fifo_rd_addr;
	logic [3:0]  fifo_empty;
	logic [63:0] channel_output_bus;
	logic [63:0] debug_observe_bus;
	logic        prev_sync;
	word_t       rd;
	int errors, samples_checked, n_sync, n_prim, n_sec, n_ten, n_hard, n_lag;

	global_test_sync_reset_regs global_test_sync_reset_regs_inst (
		.ref_clk, .reset_n, .global_word_address, .host_wr_en, .host_rd_en,
		.host_wdata, .host_rdata, .chan_test_select, .chan_test_en_mode,
		.norm_data, .norm_exp, .norm_en, .chan_sample_data, .chan_sample_exp,
		.chan_sample_en, .test_sample_scaled, .sync_input_primary,
		.sync_input_secondary, .sync_pulse_out, .sync_primary_evt,
		.sync_secondary_evt, .soft_chan_reset, .chan_slave_clear,
		.hard_reset_out, .range_source_select, .debug_enable, .norm_out_bus,
		.rc_obs, .rsmp_carry, .agc_obs, .nco_msb, .fifo_rd_addr, .fifo_empty,
		.channel_output_bus, .debug_observe_bus);
	host_cpu_model host_cpu_model_inst (
		.ref_clk, .global_word_address, .host_wr_en, .host_rd_en, .host_wdata,
		.host_rdata, .sync_input_primary, .sync_input_secondary);

	always #5 ref_clk = ~ref_clk;

	// Pulse counters, sampled before each edge's updates land
	always @(posedge ref_clk) begin
		n_sync += (sync_pulse_out === 1'b1);
		n_prim += (sync_primary_evt === 1'b1);
		n_sec += (sync_secondary_evt === 1'b1);
		n_ten += (chan_sample_en[2] === 1'b1);
		n_hard += (hard_reset_out === 1'b1);
		n_lag += (sync_primary_evt === 1'b1 && prev_sync === 1'b1);
		prev_sync = sync_pulse_out;
	end

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic finish_test;
		$display("comparisons %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic clear_counts;
		{n_sync, n_prim, n_sec, n_ten, n_hard, n_lag} = '0;
	endtask : clear_counts
	task automatic wr(input word_addr_t a, input word_t d);
		host_cpu_model_inst.write_reg(a, d);
	endtask : wr
	task automatic rd_chk(input string what, input word_addr_t a,
		input word_t e);
		host_cpu_model_inst.read_reg(a, rd);
		check(what, rd, e);
	endtask : rd_chk

	task automatic t_reset_regs;
		rd_chk("range_rst", 16'h0001, 32'h00000000);
		rd_chk("test_rst", 16'h0002, 32'h00000000);
		for (int a = 3; a < 8; a++)
			rd_chk("strobe_read", word_addr_t'(a), 32'h00000000);
	endtask : t_reset_regs
	task automatic t_regs;
		wr(16'h0001, 32'hffffffff);
		rd_chk("range_mask", 16'h0001, 32'h0000ffff);
		check("range_port", range_source_select, 16'hffff);
		wr(16'h0002, 32'hffffffff);
		rd_chk("test_mask", 16'h0002, 32'h02f7ffff);
		check("dbg_all", debug_enable, 4'hf);
		wr(16'h0002, 32'h00000000);
	endtask : t_regs
	task automatic t_sample;
		scaled_t s;
		chan_test_select = 4'b1101;
		chan_test_en_mode = {3'h7, 3'h2, 3'h0, 3'h1};
		norm_data = {4{16'h1234}};
		norm_exp = {4{3'h5}};
		norm_en = 4'hf;
		wr(16'h0002, 32'h00038001);
		tick(2);
		s = {{7{1'b1}}, 16'h8001};
		s = s << 3;
		check("ch0_data", chan_sample_data[15:0], 16'h8001);
		check("ch1_norm", chan_sample_data[31:16], 16'h1234);
		check("ch2_data", chan_sample_data[47:32], 16'h8001);
		check("ch0_exp", chan_sample_exp[2:0], 3'h3);
		check("en_on", chan_sample_en[0], 1'b1);
		check("en_norm", chan_sample_en[1], 1'b1);
		check("en_strobe_idle", chan_sample_en[2], 1'b0);
		check("en_code7", chan_sample_en[3], 1'b0);
		check("gain", test_sample_scaled, s);
		clear_counts();
		wr(16'h0003, 32'hffffffff);
		tick(4);
		check("strobe_en", n_ten, 1);
		chan_test_en_mode[11:9] = 3'h0;
		tick(1);
		check("en_off", chan_sample_en[3], 1'b0);
	endtask : t_sample
	task automatic t_sync;
		clear_counts();
		wr(16'h0004, 32'h00000000);
		tick(4);
		check("sync_out", n_sync, 1);
		check("no_feedback", n_prim, 0);
		clear_counts();
		wr(16'h0005, 32'h00000000);
		tick(4);
		check("fb_out", n_sync, 1);
		check("fb_lag", n_lag, 1);
		check("fb_prim", n_prim, 1);
		clear_counts();
		host_cpu_model_inst.sync_pulse(1'b1);
		tick(3);
		check("sec_evt", n_sec, 1);
		check("sec_alone", n_prim, 0);
		clear_counts();
		host_cpu_model_inst.sync_pulse(1'b0);
		tick(3);
		check("prim_pin", n_prim, 1);
	endtask : t_sync
	task automatic t_debug;
		logic [15:0] w;
		rc_obs = {4{6'h2a}};
		rsmp_carry = {4{2'b01}};
		agc_obs = {4{4'h9}};
		nco_msb = 4'hf;
		fifo_rd_addr = {4{3'h5}};
		fifo_empty = 4'b0100;
		norm_out_bus = {4{16'h0101}};
		w = {6'h2a, 2'b01, 4'h9, 1'b1, 3'h5};
		wr(16'h0002, 32'h00200000);
		tick(2);
		check("dbg_b", debug_enable, 4'b0010);
		check("out_b", channel_output_bus[31:16], 16'h0101 | w);
		check("out_a", channel_output_bus[15:0], 16'h0101);
		check("rc_bits", debug_observe_bus[15:10], 6'h2a);
		check("mid_bits", debug_observe_bus[9:3], w[9:3]);
		check("fifo", debug_observe_bus[2:0], 3'h5);
		check("fifo_empty", debug_observe_bus[34:32], 3'h0);
		wr(16'h0002, 32'h00000000);
		tick(2);
		check("out_b_off", channel_output_bus[31:16], 16'h0101);
	endtask : t_debug
	task automatic t_soft;
		wr(16'h0001, 32'h00005a5a);
		soft_chan_reset = 4'b0010;
		tick(1);
		check("slave_clr", chan_slave_clear, 4'b0010);
		soft_chan_reset = 4'b0000;
		tick(1);
		check("slave_idle", chan_slave_clear, 4'b0000);
		rd_chk("ctrl_kept", 16'h0001, 32'h00005a5a);
		check("no_hard", hard_reset_out, 1'b0);
	endtask : t_soft
	task automatic t_hard;
		wr(16'h0002, 32'h00100000);
		clear_counts();
		wr(16'h0006, 32'h00000000);
		tick(2);
		check("hard_pulse", n_hard, 1);
		rd_chk("range_clr", 16'h0001, 32'h00000000);
		rd_chk("test_clr", 16'h0002, 32'h00000000);
		check("dbg_clr", debug_enable, 4'h0);
	endtask : t_hard

	initial begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		chan_test_select = '0;
		chan_test_en_mode = '0;
		{norm_data, norm_exp, norm_en, norm_out_bus} = '0;
		{rc_obs, rsmp_carry, agc_obs, nco_msb, fifo_rd_addr} = '0;
		fifo_empty = 4'hf;
		soft_chan_reset = 4'h0;
		{errors, samples_checked} = '0;
		prev_sync = 1'b0;
		clear_counts();
		tick(16);
		check("hard_in_reset", hard_reset_out, 1'b1);
		reset_n = 1'b1;
		t_reset_regs();
		t_regs();
		t_sample();
		t_sync();
		t_debug();
		t_soft();
		t_hard();
		finish_test();
	end
	// All scenarios need well under a thousand cycles
	initial begin
		#100000;
		errors++;
		$display("watchdog expired");
		finish_test();
	end
endmodule : testbench
